// File: pkg/los_irq_pkg.sv
// package for the receive loss-of-signal change interrupt block
`default_nettype none
package los_irq_pkg;
    // ========================================
    // register indices; byte address is four times the index
    localparam logic [11:0] los_status_idx = 12'h012;
    localparam logic [11:0] loopback_status_idx = 12'h014;
    localparam logic [11:0] los_enable_idx = 12'h013;
    localparam logic [11:0] status_byte_idx = 12'h010;
    localparam logic [11:0] los_status_addr = {los_status_idx[9:0], 2'b00};
    localparam logic [11:0] loopback_status_addr = {loopback_status_idx[9:0], 2'b00};
    localparam logic [11:0] los_enable_addr = {los_enable_idx[9:0], 2'b00};
    localparam logic [11:0] status_byte_addr = {status_byte_idx[9:0], 2'b00};
    // ========================================
    // field layout and reset values
    localparam int los_bit = 3;
    localparam logic los_flag_reset = 1'b0;
    localparam logic los_enb_n_reset = 1'b0;
    localparam logic [7:0] reserved_hi_mask = 8'hf0;
    // ========================================
    // apb request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef enum logic [1:0] {
        acc_idle = 2'b01,
        acc_done = 2'b10
    } acc_state_t;
endpackage
`default_nettype wire

// File: rtl/los_edge_detect.sv
// edge detector turning the loss-of-signal level into a change pulse
`timescale 1ns/1ns
`default_nettype none
module los_edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic los_level,
    output logic change
);
    import los_irq_pkg::*;
    logic prev_r;
    logic prev_nxt;
    always_comb begin
        prev_nxt = los_level;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
    // both declare and clear give a change
    assign change = los_level ^ prev_r;
endmodule // los_edge_detect
`default_nettype wire

// File: rtl/rx_los_change_interrupt.sv
// receive loss-of-signal change interrupt with apb registers
// Contract
// - set status bit 3 on every declare and every clear of loss of signal
// - status reads 1 after a change since last read; reading clears it
// - interrupt only when enabled; disabled changes still recorded in status
// - enable bit 3 inverted: 0 enables, 1 disables, resets to 0
// - loopback status bits 7-4 reserved, no function in this mode
`timescale 1ns/1ns
`default_nettype none
module rx_los_change_interrupt (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic los_level,
    input wire logic [3:0] loopback_bits,
    output logic irq_n
);
    import los_irq_pkg::*;
    // ========================================
    // bus decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction
    apb_req_t req;
    logic access;
    logic los_change;
    logic flag_r;
    logic flag_nxt;
    logic enb_n_r;
    logic enb_n_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic err_r;
    logic err_nxt;
    logic mapped;
    logic setup;
    logic sel_status;
    logic sel_enable;
    logic sel_loop;
    logic status_read;
    logic status_write;
    logic enable_write;
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign access = req.psel && req.penable;
    assign mapped = hit(req.paddr, los_status_addr) || hit(req.paddr, los_enable_addr)
        || hit(req.paddr, loopback_status_addr);
    assign pready = 1'b1;
    los_edge_detect u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .los_level(los_level),
        .change(los_change)
    );
    // ========================================
    // access decode
    assign setup = req.psel && !req.penable;
    assign sel_status = hit(req.paddr, los_status_addr);
    assign sel_enable = hit(req.paddr, los_enable_addr);
    assign sel_loop = hit(req.paddr, loopback_status_addr);
    assign status_read = access && !req.pwrite && sel_status;
    assign status_write = access && req.pwrite && sel_status;
    assign enable_write = access && req.pwrite && sel_enable;
    // ========================================
    // status flag and enable
    always_comb begin
        flag_nxt = flag_r;
        enb_n_nxt = enb_n_r;
        if (status_read) begin
            flag_nxt = 1'b0;
        end
        if (los_change) begin
            flag_nxt = 1'b1;
        end
        if (enable_write) begin
            enb_n_nxt = req.pwdata[los_bit];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= los_flag_reset;
            enb_n_r <= los_enb_n_reset;
        end else begin
            flag_r <= flag_nxt;
            enb_n_r <= enb_n_nxt;
        end
    end
    // ========================================
    // read data
    always_comb begin
        rdata_nxt = rdata_r;
        err_nxt = 1'b0;
        if (req.psel && !req.penable) begin
            rdata_nxt = 32'h0;
            if (hit(req.paddr, los_status_addr)) begin
                rdata_nxt[los_bit] = flag_nxt;
            end else if (hit(req.paddr, los_enable_addr)) begin
                rdata_nxt[los_bit] = enb_n_r;
            end else if (hit(req.paddr, loopback_status_addr)) begin
                rdata_nxt[3:0] = loopback_bits;
            end
        end
        if (req.psel && !req.penable && !mapped) begin
            err_nxt = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0;
            err_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end
    // read data sampled at setup; flag cleared at access edge
    assign prdata = rdata_r;
    assign pslverr = access && err_r;
    // ========================================
    // interrupt output, active low
    assign irq_n = !(flag_r && !enb_n_r);
    // ========================================
    // assertions
    sequence change_s;
        los_change;
    endsequence
    sequence quiet_s;
        !los_change;
    endsequence
    sequence access_s;
        access;
    endsequence
    sequence status_setup_s;
        setup && sel_status;
    endsequence
    sequence enable_setup_s;
        setup && sel_enable;
    endsequence
    sequence loop_setup_s;
        setup && sel_loop;
    endsequence
    sequence stray_setup_s;
        setup && !mapped;
    endsequence
    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        change_s |=> flag_r)
        else $error("los change did not set flag");
    read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && paddr == los_status_addr && !los_change) |=> !flag_r)
        else $error("status read did not clear flag");
    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        enb_n_r |-> irq_n)
        else $error("irq asserted while disabled");
    irq_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_r && !enb_n_r) |-> !irq_n)
        else $error("irq missing while enabled");
    enb_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == los_enable_addr) |=> enb_n_r == $past(pwdata[3]))
        else $error("enable write not stored");
    resv_lb_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && paddr == loopback_status_addr) |-> prdata[7:4] == 4'h0)
        else $error("loopback reserved bits nonzero");
    resv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && (paddr == los_status_addr || paddr == los_enable_addr))
        |-> (prdata & ~32'h8) == 32'h0)
        else $error("reserved bits nonzero");
    hold_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_r && !(access && !pwrite && paddr == los_status_addr)) |=> flag_r)
        else $error("flag lost without read");
    // ========================================
    // decode, read path and interrupt cause
    no_false_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!flag_r && !los_change) |=> !flag_r)
        else $error("flag set without los change");
    set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (status_read ##0 change_s) |=> flag_r)
        else $error("change during read lost");
    status_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        (status_setup_s ##1 access_s)
        |-> prdata[los_bit] == ($past(flag_r) || $past(los_change)))
        else $error("status read value wrong");
    irq_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        (status_read ##0 quiet_s) |=> irq_n)
        else $error("irq kept after status read");
    prdata_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !setup |=> $stable(prdata))
        else $error("read data changed outside setup");
    irq_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !flag_r |-> irq_n)
        else $error("irq without pending flag");
    irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(irq_n) |-> ($past(los_change) || $past(enable_write)))
        else $error("irq raised without cause");
    enable_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_setup_s ##1 access_s)
        |-> prdata[los_bit] == $past(enb_n_r))
        else $error("enable read value wrong");
    enb_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !enable_write |=> $stable(enb_n_r))
        else $error("enable changed without write");
    loop_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        (loop_setup_s ##1 access_s)
        |-> prdata == {28'h0, $past(loopback_bits)})
        else $error("loopback read value wrong");
    stray_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (stray_setup_s ##1 access_s) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && mapped) |-> !pslverr)
        else $error("error on mapped access");
    err_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !access |-> !pslverr)
        else $error("error outside access");
    status_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (status_write && !los_change) |=> flag_r == $past(flag_r))
        else $error("status write changed flag");
endmodule // rx_los_change_interrupt
`default_nettype wire

// File: verif/rx_los_change_interrupt_tb.sv
// self-checking bench for the loss-of-signal change interrupt block
`timescale 1ns/1ns
`default_nettype none
module rx_los_change_interrupt_tb;
    import los_irq_pkg::*;
    // ========================================
    // signals and instance
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, los_level = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, irq_n;
    logic [3:0] loopback_bits = 0, lb;
    logic [32:0] notes[$];
    int bad_count = 0, checks_done = 0;
    rx_los_change_interrupt i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .los_level(los_level),
        .loopback_bits(loopback_bits), .irq_n(irq_n));
    initial begin
        forever #20 pclk = ~pclk;
    end
    // ========================================
    // checking and bus tasks
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        bit done;
        done = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && !done; n++) begin
            @(posedge pclk);
            done = (pready === 1'b1);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!done) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        notes.push_back(e);
        apb(0, a, 0);
    endtask
    task automatic irq(input logic e);
        @(negedge pclk);
        chk({32'h0, irq_n}, {32'h0, e});
    endtask
    // ========================================
    // monitor comparing read results with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (notes.size() == 0) begin
                chk(33'h0, 33'h1);
            end else begin
                chk({pslverr, prdata}, notes.pop_front());
            end
        end
    end
    // ========================================
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        void'($urandom(16793));
        rd(los_status_addr, 33'h0);
        rd(los_enable_addr, 33'h0);
        irq(1'b1);
        $display("reset values done");
        @(posedge pclk);
        los_level <= 1;
        repeat (3) @(posedge pclk);
        irq(1'b0);
        rd(los_status_addr, 33'h8);
        irq(1'b1);
        rd(los_status_addr, 33'h0);
        los_level <= 0;
        repeat (3) @(posedge pclk);
        rd(los_status_addr, 33'h8);
        $display("change flag done");
        apb(1, los_enable_addr, 32'hffffffff);
        rd(los_enable_addr, 33'h8);
        los_level <= 1;
        repeat (3) @(posedge pclk);
        irq(1'b1);
        rd(los_status_addr, 33'h8);
        apb(1, los_status_addr, 32'hff);
        rd(los_status_addr, 33'h0);
        apb(1, los_enable_addr, 32'h0);
        rd(los_enable_addr, 33'h0);
        $display("enable polarity done");
        for (int i = 0; i < 4; i++) begin
            lb = 4'($urandom);
            loopback_bits <= lb;
            rd(loopback_status_addr, {29'h0, lb});
        end
        rd(12'h0ff, 33'h100000000);
        $display("loopback and unmapped done");
        apb(1, los_enable_addr, 32'hffffffff);
        @(posedge pclk);
        presetn <= 1'b0;
        los_level <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(los_enable_addr, 33'h0);
        rd(los_status_addr, 33'h0);
        irq(1'b1);
        $display("mid-run reset done");
        chk(33'(notes.size()), 33'h0);
        stop_test();
    end
endmodule // rx_los_change_interrupt_tb
`default_nettype wire
